// ### design/pcfg_strap_decoder.sv
// Top of the port configuration strap decoder
module pcfg_strap_decoder (
    // Clock and reset
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RST_I,
    // Board straps
    input  wire logic                  SECOND_CHANNEL_ENABLE_STRAP_I,
    input  wire logic                  POLARITY_DETECT_DISABLE_STRAP_I,
    input  wire logic                  LARGE_PAYLOAD_STRAP_I,
    input  wire logic [1:0]            SLOT_PRESENCE_N_I,
    input  wire logic                  COMMON_REFCLK_STRAP_I,
    input  wire logic [1:0]            SLOT_WIRED_STRAP_I,
    input  wire logic                  SUBSTATE_VS_DEBUG_SELECT_I,
    // Switch core side
    input  wire logic [2:0]            PORT_STATUS_I,
    input  wire logic [2:0]            PORT_L1SS_REQ_I,
    output logic                       CFG_VALID_O,
    output pcfg_pkg::pcfg_cfg_t        CFG_O,
    output logic                       DEBUG_MODE_O,
    output logic [2:0]                 REFCLK_ON_O,
    output logic [2:0]                 PLL_ON_O,
    output logic [2:0]                 IN_L1SS_O,
    // Shared pin group
    input  wire logic [2:0]            REFCLK_REQUEST_N_I,
    output logic [2:0]                 LINK_STATE_DEBUG_OUT_O,
    output logic [2:0]                 LINK_STATE_DEBUG_OE_O
);
    // Two-flop synchronisers on every strap and clock request pin
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] next_sync1;
    logic [11:0] next_sync2;
    logic [11:0] pins;
    assign pins = {SECOND_CHANNEL_ENABLE_STRAP_I, POLARITY_DETECT_DISABLE_STRAP_I,
                   LARGE_PAYLOAD_STRAP_I, SLOT_PRESENCE_N_I, COMMON_REFCLK_STRAP_I,
                   SLOT_WIRED_STRAP_I, SUBSTATE_VS_DEBUG_SELECT_I, REFCLK_REQUEST_N_I};

    always_comb begin
        next_sync1 = pins;
        next_sync2 = sync1;
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1 <= pcfg_pkg::SYNC_RST;
            sync2 <= pcfg_pkg::SYNC_RST;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    logic       s_vc1;
    logic       s_poldis;
    logic       s_mps;
    logic [1:0] s_slot_presence_n_n;
    logic       s_cclk;
    logic [1:0] s_wired;
    logic       s_sel;
    logic [2:0] s_req_n;
    assign {s_vc1, s_poldis, s_mps, s_slot_presence_n_n, s_cclk, s_wired, s_sel, s_req_n} = sync2;

    // Two waits after release so sync2 holds pin levels, not its reset zeros
    pcfg_pkg::pcfg_state_t state;
    pcfg_pkg::pcfg_state_t next_state;
    pcfg_pkg::pcfg_cfg_t   cfg;
    pcfg_pkg::pcfg_cfg_t   next_cfg;
    logic                  valid;
    logic                  next_valid;
    logic                  dbg;
    logic                  next_dbg;

    always_comb begin
        next_state = state;
        next_cfg   = cfg;
        next_valid = valid;
        next_dbg   = dbg;
        case (state)
            pcfg_pkg::PCFG_IN_RESET: begin
                next_state = pcfg_pkg::PCFG_SETTLE;
            end
            pcfg_pkg::PCFG_SETTLE: begin
                next_state = pcfg_pkg::PCFG_SAMPLE;
            end
            pcfg_pkg::PCFG_SAMPLE: begin
                next_state = pcfg_pkg::PCFG_RUN;
                next_valid = 1'h1;
                next_dbg   = s_sel;
                next_cfg.vc1_enable         = s_vc1;
                next_cfg.vc_share_avail     = 1'h0;
                next_cfg.vc1_to_vc0         = ~s_vc1;
                next_cfg.polarity_detect_en = ~s_poldis;
                next_cfg.max_payload_code   = s_mps ? pcfg_pkg::MPS_CODE_512
                                                    : pcfg_pkg::MPS_CODE_256;
                next_cfg.slot_present       = ~s_slot_presence_n_n;
                next_cfg.common_refclk      = s_cclk;
                next_cfg.slot_wired         = s_wired;
            end
            pcfg_pkg::PCFG_RUN: begin
                next_state = pcfg_pkg::PCFG_RUN;
            end
            default: begin
                next_state = pcfg_pkg::PCFG_IN_RESET;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= pcfg_pkg::PCFG_IN_RESET;
            cfg   <= pcfg_pkg::CFG_RST;
            valid <= pcfg_pkg::VALID_RST;
            dbg   <= pcfg_pkg::DEBUG_RST;
        end else begin
            state <= next_state;
            cfg   <= next_cfg;
            valid <= next_valid;
            dbg   <= next_dbg;
        end
    end

    // Shared pin group; clock gating only acts once straps are valid
    logic [2:0] refclk_on;
    logic [2:0] l1ss;
    logic [2:0] dout;
    logic [2:0] doe;

    // One handler per port, so a stuck pin spoils only its own port
    for (genvar p = 0; p < pcfg_pkg::NUM_PORTS; p++) begin : g_port
        pcfg_port_pins port_u (
            .clk_i       (CORE_CLK_I),
            .rst_i       (RST_I),
            .valid_i     (valid),
            .debug_i     (dbg),
            .req_n_i     (s_req_n[p]),
            .status_i    (PORT_STATUS_I[p]),
            .l1ss_req_i  (PORT_L1SS_REQ_I[p]),
            .refclk_on_o (refclk_on[p]),
            .in_l1ss_o   (l1ss[p]),
            .dout_o      (dout[p]),
            .doe_o       (doe[p])
        );
    end

    assign CFG_VALID_O            = valid;
    assign CFG_O                  = cfg;
    assign DEBUG_MODE_O           = dbg;
    assign REFCLK_ON_O            = refclk_on;
    assign PLL_ON_O               = refclk_on;
    assign IN_L1SS_O              = l1ss;
    assign LINK_STATE_DEBUG_OUT_O = dout;
    assign LINK_STATE_DEBUG_OE_O  = doe;
endmodule : pcfg_strap_decoder

// One port of the shared pin group
module pcfg_port_pins (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Captured mode
    input  wire logic valid_i,
    input  wire logic debug_i,
    // Synchronised request pin and core status
    input  wire logic req_n_i,
    input  wire logic status_i,
    input  wire logic l1ss_req_i,
    // Per-port results
    output logic      refclk_on_o,
    output logic      in_l1ss_o,
    output logic      dout_o,
    output logic      doe_o
);
    logic refclk_on;
    logic next_refclk_on;
    logic l1ss;
    logic next_l1ss;
    logic dout;
    logic next_dout;
    logic doe;
    logic next_doe;

    // Clocks held on until the straps are known, so boot never stalls
    always_comb begin
        next_refclk_on = pcfg_pkg::REFCLK_ON_RST;
        next_l1ss      = pcfg_pkg::L1SS_RST;
        next_dout      = pcfg_pkg::DOUT_RST;
        next_doe       = pcfg_pkg::DOE_RST;
        if (valid_i && debug_i) begin
            next_doe  = 1'h1;
            next_dout = status_i;
        end else if (valid_i) begin
            next_refclk_on = ~req_n_i;
            next_l1ss      = req_n_i & l1ss_req_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            refclk_on <= pcfg_pkg::REFCLK_ON_RST;
            l1ss      <= pcfg_pkg::L1SS_RST;
            dout      <= pcfg_pkg::DOUT_RST;
            doe       <= pcfg_pkg::DOE_RST;
        end else begin
            refclk_on <= next_refclk_on;
            l1ss      <= next_l1ss;
            dout      <= next_dout;
            doe       <= next_doe;
        end
    end

    assign refclk_on_o = refclk_on;
    assign in_l1ss_o   = l1ss;
    assign dout_o      = dout;
    assign doe_o       = doe;
endmodule : pcfg_port_pins

// ### design/pcfg_pkg.sv
// Package for the port configuration strap decoder
package pcfg_pkg;
    localparam int NUM_DS_PORTS = 2;
    localparam int NUM_PORTS = 3;
    localparam logic [11:0] MPS_512_BYTES = 12'h200;
    localparam logic [11:0] MPS_256_BYTES = 12'h100;
    localparam logic [2:0] MPS_CODE_512 = 3'h2;
    localparam logic [2:0] MPS_CODE_256 = 3'h1;
    localparam logic [2:0] MPS_CODE_RST = 3'h1;
    localparam logic [11:0] SYNC_RST     = 12'h0;
    localparam logic        VALID_RST    = 1'h0;
    localparam logic        DEBUG_RST    = 1'h0;
    localparam logic        REFCLK_ON_RST = 1'h1;
    localparam logic        L1SS_RST     = 1'h0;
    localparam logic        DOUT_RST     = 1'h0;
    localparam logic        DOE_RST      = 1'h0;

    typedef struct packed {
        logic       vc1_enable;
        logic       vc_share_avail;
        logic       vc1_to_vc0;
        logic       polarity_detect_en;
        logic [2:0] max_payload_code;
        logic [1:0] slot_present;
        logic       common_refclk;
        logic [1:0] slot_wired;
    } pcfg_cfg_t;

    localparam pcfg_cfg_t CFG_RST = '{vc1_enable: 1'h0, vc_share_avail: 1'h0,
        vc1_to_vc0: 1'h1, polarity_detect_en: 1'h1, max_payload_code: MPS_CODE_RST,
        slot_present: 2'h0, common_refclk: 1'h0, slot_wired: 2'h0};

    typedef enum logic [1:0] {
        PCFG_IN_RESET,
        PCFG_SETTLE,
        PCFG_SAMPLE,
        PCFG_RUN
    } pcfg_state_t;
endpackage : pcfg_pkg

// ### bench/pcfg_slot_model.sv
// Downstream device model driving the shared clock request pins
module pcfg_slot_model (
    // Clock and command
    input  logic       clk_i,
    input  logic [2:0] sleep_i,
    // Request pins, active low
    // Starts awake so the link keeps its clock
    output logic [2:0] req_n_o = 3'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Request dropped to sleep, raised again to wake
    always @(posedge clk_i) req_n_o <= #1 sleep_i;
endmodule : pcfg_slot_model

// ### bench/pcfg_sd_chk_assertions.sv
// Checker for the port configuration strap decoder
module pcfg_sd_chk (
    // Watched ports
    input logic                CORE_CLK_I,
    input logic                RST_I,
    input logic                CFG_VALID_O,
    input pcfg_pkg::pcfg_cfg_t CFG_O,
    input logic                DEBUG_MODE_O,
    input logic [2:0]          REFCLK_ON_O,
    input logic [2:0]          IN_L1SS_O,
    input logic [2:0]          REFCLK_REQUEST_N_I,
    input logic [2:0]          PORT_STATUS_I,
    input logic [2:0]          LINK_STATE_DEBUG_OE_O,
    input logic [2:0]          LINK_STATE_DEBUG_OUT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Two sync stages plus the output register
    sequence s_req_held;
        (CFG_VALID_O && !DEBUG_MODE_O && REFCLK_REQUEST_N_I == 3'h0) [*4];
    endsequence
    a_vc_split: assert property (CFG_VALID_O |-> CFG_O.vc1_enable != CFG_O.vc1_to_vc0)
        else $error("channel split wrong");
    a_cfg_hold: assert property (CFG_VALID_O |=> $stable(CFG_O))
        else $error("config moved");
    a_valid_soon: assert property ($fell(RST_I) |-> ##[1:3] CFG_VALID_O)
        else $error("config late");
    a_req_quiet: assert property (CFG_VALID_O && !DEBUG_MODE_O |=> LINK_STATE_DEBUG_OE_O == 3'h0)
        else $error("pins driven");
    a_dbg_drive: assert property (CFG_VALID_O && DEBUG_MODE_O |=> LINK_STATE_DEBUG_OE_O == 3'h7)
        else $error("pins not driven");
    a_dbg_status: assert property ((CFG_VALID_O && DEBUG_MODE_O) [*2] |=>
        LINK_STATE_DEBUG_OUT_O == $past(PORT_STATUS_I)) else $error("status wrong");
    a_l1_clk_off: assert property ((IN_L1SS_O & REFCLK_ON_O) == 3'h0)
        else $error("clock on in substate");
    a_req_wake: assert property (s_req_held |-> REFCLK_ON_O == 3'h7 && IN_L1SS_O == 3'h0)
        else $error("no wake");
endmodule : pcfg_sd_chk

bind pcfg_strap_decoder pcfg_sd_chk chk_u (.*);

// ### bench/test_pcfg_strap_decoder.sv
// Bench for the port configuration strap decoder
module test_pcfg_strap_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, vc = 0, pd = 0, lp = 0, cc = 0, sel = 0, cv, dm;
    logic [1:0] pn = 0, sw = 0;
    logic [2:0] st = 0, l1 = 0, sl = 0, rq_n, dbg, oe, ron, pll, inl;
    pcfg_pkg::pcfg_cfg_t cfg, ex;
    int fails = 0, total_checks = 0, cyc = 0;
    pcfg_strap_decoder dut_u (.CORE_CLK_I(clk), .RST_I(rst),
        .SECOND_CHANNEL_ENABLE_STRAP_I(vc), .POLARITY_DETECT_DISABLE_STRAP_I(pd),
        .LARGE_PAYLOAD_STRAP_I(lp), .SLOT_PRESENCE_N_I(pn), .COMMON_REFCLK_STRAP_I(cc),
        .SLOT_WIRED_STRAP_I(sw), .SUBSTATE_VS_DEBUG_SELECT_I(sel), .PORT_STATUS_I(st),
        .PORT_L1SS_REQ_I(l1), .CFG_VALID_O(cv), .CFG_O(cfg), .DEBUG_MODE_O(dm),
        .REFCLK_ON_O(ron), .PLL_ON_O(pll), .IN_L1SS_O(inl), .REFCLK_REQUEST_N_I(rq_n),
        .LINK_STATE_DEBUG_OUT_O(dbg), .LINK_STATE_DEBUG_OE_O(oe));
    pcfg_slot_model slot_u (.clk_i(clk), .sleep_i(sl), .req_n_o(rq_n));
    initial forever #20 clk = ~clk;
    task step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task chk(string n, logic [11:0] e, logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task close_out;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    // Straps flipped after capture must not leak through
    task boot(logic v);
        rst = 1;
        {vc, pd, lp, cc, sel, pn, sw} = {{5{v}}, v, ~v, ~v, v};
        step(20);
        chk("valid", 12'h0, {11'h0, cv});
        chk("cfg rst", pcfg_pkg::CFG_RST, cfg);
        ex = '{v, 1'h0, ~v, ~v, v ? pcfg_pkg::MPS_CODE_512 : pcfg_pkg::MPS_CODE_256, ~pn, v, sw};
        rst = 0;
        step(4);
        chk("valid set", 12'h1, {11'h0, cv});
        chk("cfg", ex, cfg);
        {vc, pd, lp, cc, pn, sw} = ~{vc, pd, lp, cc, pn, sw};
        step(4);
        chk("cfg held", ex, cfg);
        chk("mode", {11'h0, v}, {11'h0, dm});
    endtask : boot
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        for (int i = 0; i < 2; i++) begin
            boot(i[0]);
            st = 3'h5;
            l1 = 3'h3;
            sl = 3'h6;
            step(6);
            if (i == 0) begin
                chk("refclk", 12'h1, {9'h0, ron});
                chk("pll", 12'h1, {9'h0, pll});
                chk("l1ss", 12'h2, {9'h0, inl});
                chk("oe", 12'h0, {9'h0, oe});
                sl = 3'h0;
                step(6);
                chk("pll back", 12'h7, {9'h0, pll});
                chk("l1ss left", 12'h0, {9'h0, inl});
            end else begin
                chk("status", 12'h5, {9'h0, dbg});
                chk("oe", 12'h7, {9'h0, oe});
                chk("refclk", 12'h7, {9'h0, ron});
            end
        end
        close_out();
    end
endmodule : test_pcfg_strap_decoder
